// ### shared/cms_pkg.sv
// constants for the clock multiplier and clock select block
// assumes an 8-bit special function register port on the ref_clk domain
package cms_pkg;
    localparam int CMS_REF_MHZ = 100;
    localparam logic [7:0] CMS_MULCTL_ADDR = 8'hB9;
    localparam logic [7:0] CMS_CLOCK_SELECT_REG_ADDR = 8'hA9;
    localparam logic [7:0] CMS_MULCTL_RESET = 8'h00;
    localparam logic [7:0] CMS_CLOCK_SELECT_REG_RESET = 8'h00;
    localparam logic [7:0] CMS_CLOCK_SELECT_REG_WMASK = 8'h77;
    localparam int CMS_MUL_EN_BIT = 7;
    localparam int CMS_MUL_INIT_BIT = 6;
    localparam int CMS_MUL_RDY_BIT = 5;
    localparam int CMS_MUL_SEL_LSB = 0;
    localparam int CMS_USB_SEL_LSB = 4;
    localparam int CMS_SYS_SEL_LSB = 0;
    localparam int CMS_MUL_FACTOR = 4;
    localparam int CMS_LOCK_PERIODS = 8;
    localparam int CMS_XTAL_SETTLE_TICKS = 1024;
    localparam int CMS_PERIOD_W = 12;
    typedef enum logic [1:0] {
        CMS_MIN_INT = 2'h0,
        CMS_MIN_EXT = 2'h1,
        CMS_MIN_EXT2 = 2'h2,
        CMS_MIN_RSVD = 2'h3
    } cms_mul_in_t;
    typedef enum logic [2:0] {
        CMS_USB_MUL = 3'h0,
        CMS_USB_INT2 = 3'h1,
        CMS_USB_EXT = 3'h2,
        CMS_USB_EXT2 = 3'h3,
        CMS_USB_EXT3 = 3'h4,
        CMS_USB_EXT4 = 3'h5
    } cms_usb_src_t;
    typedef enum logic [2:0] {
        CMS_SYS_INT = 3'h0,
        CMS_SYS_EXT = 3'h1,
        CMS_SYS_MUL2 = 3'h2,
        CMS_SYS_MUL = 3'h3,
        CMS_SYS_LFO = 3'h4
    } cms_sys_src_t;
    typedef enum logic [3:0] {
        CMS_ST_OFF = 4'b0001,
        CMS_ST_ON = 4'b0010,
        CMS_ST_INIT = 4'b0100,
        CMS_ST_LOCK = 4'b1000
    } cms_mul_state_t;
endpackage

// ### hdl/cms_multiplier.sv
// times-four tick multiplier with lock detection
// assumes input ticks are one-cycle pulses on ref_clk, slower than a quarter of it
`timescale 1ns/100ps
module cms_multiplier #(
    parameter int LOCK_PERIODS = cms_pkg::CMS_LOCK_PERIODS,
    parameter int PERIOD_W = cms_pkg::CMS_PERIOD_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic inTick,
    input wire logic enable,
    input wire logic initStart,
    // result
    output logic tickOut,
    output logic locked
);
    import cms_pkg::*;
    if (LOCK_PERIODS < 1 || LOCK_PERIODS > 255 || PERIOD_W < 4) begin : gBadParams
        $error("cms_multiplier: unsupported parameters");
    end
    cms_mul_state_t state_reg, state_next;
    logic [PERIOD_W-1:0] cnt_reg, cnt_next, period_reg, period_next;
    logic [7:0] stable_reg, stable_next;
    logic tick_reg, tick_next;
    logic [PERIOD_W-1:0] quarter, measured, diff;

    always_comb begin
        measured = cnt_reg + {{(PERIOD_W-1){1'b0}}, 1'b1};
        quarter = period_reg >> 2;
        diff = (measured > period_reg) ? measured - period_reg : period_reg - measured;
        state_next = state_reg;
        stable_next = stable_reg;
        period_next = period_reg;
        cnt_next = (&cnt_reg) ? cnt_reg : measured;
        if (inTick) begin
            cnt_next = '0;
            period_next = measured;
        end
        case (state_reg)
            CMS_ST_OFF: begin
                if (enable) begin
                    state_next = CMS_ST_ON;
                end
            end
            CMS_ST_ON: begin
                if (initStart) begin
                    state_next = CMS_ST_INIT;
                    stable_next = 8'h00;
                end
            end
            CMS_ST_INIT: begin
                if (inTick) begin
                    if (diff <= {{(PERIOD_W-1){1'b0}}, 1'b1}) begin
                        stable_next = stable_reg + 8'h01;
                    end else begin
                        stable_next = 8'h00;
                    end
                    if (stable_reg == 8'(LOCK_PERIODS - 1)) begin
                        state_next = CMS_ST_LOCK; // R5
                    end
                end
            end
            CMS_ST_LOCK: begin
                state_next = CMS_ST_LOCK;
            end
            default: begin
                state_next = CMS_ST_OFF;
            end
        endcase
        if (!enable) begin
            state_next = CMS_ST_OFF; // R20
        end
        // four evenly spaced pulses per input period
        tick_next = (state_reg == CMS_ST_LOCK) && enable && quarter != '0 &&
                    (inTick || cnt_next == quarter || cnt_next == (quarter << 1) ||
                     cnt_next == quarter + (quarter << 1)); // R1
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= CMS_ST_OFF;
            cnt_reg <= '0;
            period_reg <= '0;
            stable_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            period_reg <= period_next;
            stable_reg <= stable_next;
            tick_reg <= tick_next;
        end
    end

    assign tickOut = tick_reg;
    // gated by enable so the ready bit drops in the same cycle as the enable bit
    assign locked = (state_reg == CMS_ST_LOCK) && enable; // R5 R20
endmodule

// ### hdl/cms_clock_control.sv
// clock multiplier control and system / usb clock selection
// assumes oscillator pins arrive asynchronously; clocks are modelled as ref_clk tick enables
// Notes on behaviour
// R1: multiplier gives four times its input rate
// R2: software resets, selects, enables, waits, initialises, polls
// R3: bit 7 enables the multiplier
// R4: bit 6 starts init only when enabled
// R5: read-only bit 5 shows multiplier lock
// R6: low two bits pick multiplier input
// R7: external source stable before multiplier init
// R8: internal oscillator selectable without start-up wait
// R9: crystal-valid set once external oscillator settles
// R10: software waits 1 ms before reading crystal-valid
// R11: system runs on external only for 01
// R12: system source switchable on the fly
// R13: divided multiplier allowed; full only on variants
// R14: software sets flash timing above 25 MHz
// R15: software picks 48 or 6 MHz usb clock
// R16: usb from multiplier or divided oscillators; code also offers the undivided external oscillator at 010
// R17: software enables clock recovery for 000/00
// R18: bits 6-4 choose usb clock source
// R19: bits 2-0 choose system clock source
// R20: ready clears when multiplier disabled
// R21: multiplier control bits 4-2 read zero
`timescale 1ns/100ps
module cms_clock_control #(
    parameter bit FULL_RATE_SYS = 1'b1,
    parameter int XTAL_SETTLE_TICKS = cms_pkg::CMS_XTAL_SETTLE_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    // oscillator pins and external oscillator control
    input wire logic intOscPin,
    input wire logic extOscPin,
    input wire logic lfoPin,
    input wire logic extOscEnable,
    // clock enables and status
    output logic sysClkTick,
    output logic usbClkTick,
    output logic crystalValid
);
    import cms_pkg::*;
    if (XTAL_SETTLE_TICKS < 1 || XTAL_SETTLE_TICKS > 65535) begin : gBadSettle
        $error("cms_clock_control: unsupported settle count");
    end
    // pin synchronisers and edge detection
    logic [2:0] syncA_reg, syncB_reg, prev_reg;
    logic [2:0] syncA_next, syncB_next, prev_next, pinTick;
    always_comb begin
        syncA_next = {lfoPin, extOscPin, intOscPin};
        syncB_next = syncA_reg;
        prev_next = syncB_reg;
        pinTick = syncB_reg & ~prev_reg;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
            prev_reg <= 3'h0;
        end else begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
            prev_reg <= prev_next;
        end
    end
    logic intTick, extTick, lfoTick;
    assign intTick = pinTick[0];
    assign extTick = pinTick[1];
    assign lfoTick = pinTick[2];

    // registers
    logic multiplier_enable_reg, multiplier_enable_next;
    logic multiplier_initialise_reg, multiplier_initialise_next;
    logic [1:0] multiplier_input_select_reg, multiplier_input_select_next;
    logic [7:0] clock_select_reg_reg, clock_select_reg_next;
    logic [7:0] rd_reg, rd_next;
    logic initStart, mulLocked, mulTick;
    logic [2:0] usbSel, sysSel;
    assign usbSel = clock_select_reg_reg[CMS_USB_SEL_LSB +: 3];
    assign sysSel = clock_select_reg_reg[CMS_SYS_SEL_LSB +: 3];
    always_comb begin
        multiplier_enable_next = multiplier_enable_reg;
        multiplier_initialise_next = multiplier_initialise_reg;
        multiplier_input_select_next = multiplier_input_select_reg;
        clock_select_reg_next = clock_select_reg_reg;
        initStart = 1'b0;
        if (sfrWrite && sfrAddr == CMS_MULCTL_ADDR) begin
            multiplier_enable_next = sfrWrData[CMS_MUL_EN_BIT]; // R3
            multiplier_initialise_next = sfrWrData[CMS_MUL_INIT_BIT];
            multiplier_input_select_next = sfrWrData[CMS_MUL_SEL_LSB +: 2]; // R6
            initStart = sfrWrData[CMS_MUL_INIT_BIT] && sfrWrData[CMS_MUL_EN_BIT] && multiplier_enable_reg; // R4
        end
        if (sfrWrite && sfrAddr == CMS_CLOCK_SELECT_REG_ADDR) begin
            clock_select_reg_next = sfrWrData & CMS_CLOCK_SELECT_REG_WMASK; // R12
        end
        rd_next = 8'h00;
        if (sfrAddr == CMS_MULCTL_ADDR) begin
            rd_next = {multiplier_enable_reg, multiplier_initialise_reg, mulLocked, 3'b000, multiplier_input_select_reg}; // R21
        end else if (sfrAddr == CMS_CLOCK_SELECT_REG_ADDR) begin
            rd_next = clock_select_reg_reg;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            multiplier_enable_reg <= CMS_MULCTL_RESET[CMS_MUL_EN_BIT];
            multiplier_initialise_reg <= CMS_MULCTL_RESET[CMS_MUL_INIT_BIT];
            multiplier_input_select_reg <= CMS_MULCTL_RESET[1:0];
            clock_select_reg_reg <= CMS_CLOCK_SELECT_REG_RESET;
            rd_reg <= 8'h00;
        end else begin
            multiplier_enable_reg <= multiplier_enable_next;
            multiplier_initialise_reg <= multiplier_initialise_next;
            multiplier_input_select_reg <= multiplier_input_select_next;
            clock_select_reg_reg <= clock_select_reg_next;
            rd_reg <= rd_next;
        end
    end
    assign sfrRdData = rd_reg;

    // dividers: external /2 for multiplier input, and the selected usb / system rates
    logic extHalf_reg, extHalf_next, mulHalf_reg, mulHalf_next, intHalf_reg, intHalf_next;
    logic [1:0] usbDiv_reg, usbDiv_next;
    logic mulInTick;
    always_comb begin
        extHalf_next = extHalf_reg ^ extTick;
        mulHalf_next = mulHalf_reg ^ mulTick;
        intHalf_next = intHalf_reg ^ intTick;
        case (cms_mul_in_t'(multiplier_input_select_reg))
            CMS_MIN_INT: mulInTick = intTick; // R6
            CMS_MIN_EXT: mulInTick = extTick;
            CMS_MIN_EXT2: mulInTick = extTick && extHalf_reg;
            default: mulInTick = 1'b0;
        endcase
    end

    cms_multiplier #(
        .LOCK_PERIODS(CMS_LOCK_PERIODS),
        .PERIOD_W(CMS_PERIOD_W)
    ) u_mul (
        .ref_clk(ref_clk),
        .rst(rst),
        .inTick(mulInTick),
        .enable(multiplier_enable_reg), // R20
        .initStart(initStart),
        .tickOut(mulTick), // R1
        .locked(mulLocked)
    );

    // usb and system clock selection
    logic usbNext, sysNext, usbTick_reg, sysTick_reg;
    logic [1:0] usbDivMax;
    always_comb begin
        usbNext = 1'b0;
        usbDivMax = 2'h0;
        case (cms_usb_src_t'(usbSel))
            CMS_USB_MUL: usbNext = mulTick; // R16
            CMS_USB_INT2: usbNext = intTick && intHalf_reg;
            CMS_USB_EXT: usbNext = extTick;
            CMS_USB_EXT2: usbDivMax = 2'h1;
            CMS_USB_EXT3: usbDivMax = 2'h2;
            CMS_USB_EXT4: usbDivMax = 2'h3;
            default: usbNext = 1'b0; // R18
        endcase
        usbDiv_next = usbDiv_reg;
        if (usbDivMax != 2'h0 && extTick) begin
            usbDiv_next = (usbDiv_reg >= usbDivMax) ? 2'h0 : usbDiv_reg + 2'h1;
            usbNext = (usbDiv_reg >= usbDivMax); // R18
        end
        case (cms_sys_src_t'(sysSel))
            CMS_SYS_INT: sysNext = intTick; // R8
            CMS_SYS_EXT: sysNext = extTick; // R11
            CMS_SYS_MUL2: sysNext = mulTick && mulHalf_reg; // R13
            CMS_SYS_MUL: sysNext = mulTick && FULL_RATE_SYS; // R13
            CMS_SYS_LFO: sysNext = lfoTick; // R19
            default: sysNext = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            extHalf_reg <= 1'b0;
            mulHalf_reg <= 1'b0;
            intHalf_reg <= 1'b0;
            usbDiv_reg <= 2'h0;
            usbTick_reg <= 1'b0;
            sysTick_reg <= 1'b0;
        end else begin
            extHalf_reg <= extHalf_next;
            mulHalf_reg <= mulHalf_next;
            intHalf_reg <= intHalf_next;
            usbDiv_reg <= usbDiv_next;
            usbTick_reg <= usbNext;
            sysTick_reg <= sysNext;
        end
    end
    assign usbClkTick = usbTick_reg;
    assign sysClkTick = sysTick_reg;

    // crystal settle detection
    logic [15:0] settle_reg, settle_next;
    logic valid_reg, valid_next;
    always_comb begin
        settle_next = settle_reg;
        valid_next = valid_reg;
        if (!extOscEnable) begin
            settle_next = 16'h0000;
            valid_next = 1'b0;
        end else if (extTick && !valid_reg) begin
            settle_next = settle_reg + 16'h0001;
            valid_next = (settle_reg == 16'(XTAL_SETTLE_TICKS - 1)); // R9
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settle_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            settle_reg <= settle_next;
            valid_reg <= valid_next;
        end
    end
    assign crystalValid = valid_reg;
endmodule

// ### test/cms_monitor.sv
// checker for the clock control block ports
// assumes it is bound onto cms_clock_control
`timescale 1ns/100ps
module cms_monitor import cms_pkg::*; #(
    parameter bit FULL_RATE_SYS = 1'b1,
    parameter int XTAL_SETTLE_TICKS = CMS_XTAL_SETTLE_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] sfrRdData,
    // oscillators
    input wire logic intOscPin,
    input wire logic extOscPin,
    input wire logic lfoPin,
    input wire logic extOscEnable,
    // clock enables and status
    input wire logic sysClkTick,
    input wire logic usbClkTick,
    input wire logic crystalValid
);
    logic [7:0] selMirror_reg;
    logic [7:0] selMirror_next;
    logic sysRsvd;
    always_comb begin
        selMirror_next = selMirror_reg;
        if (sfrWrite && sfrAddr == CMS_CLOCK_SELECT_REG_ADDR) begin
            selMirror_next = sfrWrData & CMS_CLOCK_SELECT_REG_WMASK;
        end
    end
    always_ff @(posedge ref_clk) begin
        selMirror_reg <= rst ? CMS_CLOCK_SELECT_REG_RESET : selMirror_next;
    end
    assign sysRsvd = selMirror_reg[2:0] > 3'h4 || (selMirror_reg[2:0] == 3'h3 && !FULL_RATE_SYS);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sDisableWrite;
        sfrWrite && sfrAddr == CMS_MULCTL_ADDR && !sfrWrData[7];
    endsequence
    sequence sHoldAddr;
        sfrAddr == CMS_MULCTL_ADDR;
    endsequence
    AST_LOCK_CLEAR: assert property (sDisableWrite ##1 sHoldAddr |=> !sfrRdData[5])
        else $error("lock flag kept after disable");
    AST_LOCK_RISE: assert property ($rose(sfrRdData[5]) && $past(sfrAddr) == CMS_MULCTL_ADDR
        && $past(sfrAddr, 2) == CMS_MULCTL_ADDR |-> sfrRdData[7]) else $error("lock without enable");
    AST_UNUSED_ZERO: assert property (sHoldAddr |=> sfrRdData[4:2] == 3'h0)
        else $error("unused bits not zero");
    AST_SYS_RSVD: assert property (sysRsvd && $past(sysRsvd) |-> !sysClkTick)
        else $error("tick on reserved system source");
    AST_USB_RSVD: assert property (selMirror_reg[6:5] == 2'h3 && $past(selMirror_reg[6:5]) == 2'h3
        |-> !usbClkTick) else $error("tick on reserved usb source");
    AST_SYS_INT: assert property ((selMirror_reg[2:0] == 3'h0 && $stable(intOscPin))[*7]
        |-> !sysClkTick) else $error("system tick without internal edge");
    AST_SYS_EXT: assert property ((selMirror_reg[2:0] == 3'h1 && $stable(extOscPin))[*7]
        |-> !sysClkTick) else $error("system tick without external edge");
    AST_XTAL_CLEAR: assert property (!extOscEnable |=> !crystalValid)
        else $error("crystal valid while disabled");
    AST_XTAL_SETTLE: assert property ($rose(extOscEnable) |-> !crystalValid [*8])
        else $error("crystal valid too early");
endmodule
bind cms_clock_control cms_monitor #(.FULL_RATE_SYS(FULL_RATE_SYS), .XTAL_SETTLE_TICKS(XTAL_SETTLE_TICKS)) mon_u (
    .ref_clk, .rst, .sfrAddr, .sfrWrite, .sfrWrData, .sfrRdData, .intOscPin, .extOscPin,
    .lfoPin, .extOscEnable, .sysClkTick, .usbClkTick, .crystalValid);

// ### test/cms_osc_model.sv
// oscillator sources feeding the clock control pins
// assumes the internal and external sources stand still while their enable is low
`timescale 1ns/100ps
module cms_osc_model #(
    parameter real INT_HALF = 42.0,
    parameter real EXT_HALF = 40.0,
    parameter real LFO_HALF = 200.0
) (
    // enables
    input wire logic intOn,
    input wire logic extOn,
    // pins
    output logic intOscPin = 1'b0,
    output logic extOscPin = 1'b0,
    output logic lfoPin = 1'b0
);
    always #(INT_HALF) intOscPin = intOn ? ~intOscPin : intOscPin;
    always #(EXT_HALF) extOscPin = extOn ? ~extOscPin : extOscPin;
    always #(LFO_HALF) lfoPin = ~lfoPin;
endmodule

// ### test/tb_top.sv
// self-checking bench for the clock control block
// assumes the oscillator model drives the pins
`timescale 1ns/100ps
module tb_top;
    import cms_pkg::*;
    localparam int TI = 84;
    localparam int TE = 80;
    localparam int TL = 400;
    localparam int W = 1680;
    typedef struct {logic [7:0] sel; logic [7:0] rdExp; int sysN; int usbN;} cms_row_t;
    cms_row_t rows[7] = '{'{8'h10, 8'h10, W/TI, W/(2*TI)}, '{8'h21, 8'h21, W/TE, W/TE},
        '{8'h02, 8'h02, 2*W/TI, 4*W/TI}, '{8'h33, 8'h33, 4*W/TI, W/(2*TE)},
        '{8'h44, 8'h44, W/TL, W/(3*TE)}, '{8'h55, 8'h55, 0, W/(4*TE)}, '{8'hFF, 8'h77, 0, 0}};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrite = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData;
    logic intOscPin, extOscPin, lfoPin, sysClkTick, usbClkTick, crystalValid;
    logic extOscEnable = 1'b0;
    logic intOscOn = 1'b0;
    logic [7:0] rv;
    int miscompares = 0;
    int n_compared = 0;
    int sysCnt, usbCnt;
    always #5 ref_clk = ~ref_clk;
    cms_clock_control #(.XTAL_SETTLE_TICKS(8)) dut_u (.ref_clk, .rst, .sfrAddr, .sfrWrite, .sfrWrData,
        .sfrRdData, .intOscPin, .extOscPin, .lfoPin, .extOscEnable, .sysClkTick, .usbClkTick, .crystalValid);
    cms_osc_model osc_u (.intOn(intOscOn), .extOn(extOscEnable), .intOscPin, .extOscPin, .lfoPin);
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrite = 1'b1;
        tick(1);
        sfrWrite = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        sfrAddr = a;
        tick(2);
        rv = sfrRdData;
    endtask
    task automatic chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkCount(input string n, input int e, input int g);
        n_compared++;
        if (g > e + 1 || g < e - 1) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic countTicks();
        sysCnt = 0;
        usbCnt = 0;
        repeat (W / 10) begin
            tick(1);
            sysCnt += int'(sysClkTick === 1'b1);
            usbCnt += int'(usbClkTick === 1'b1);
        end
    endtask
    task automatic bringUp(input logic [1:0] s);
        wr(CMS_MULCTL_ADDR, 8'h00);
        wr(CMS_MULCTL_ADDR, {6'h00, s});
        wr(CMS_MULCTL_ADDR, {6'h20, s});
        tick(510);
        wr(CMS_MULCTL_ADDR, {6'h30, s});
        rv = 8'h00;
        for (int i = 0; i < 200 && rv[5] !== 1'b1; i++) begin
            rd(CMS_MULCTL_ADDR);
        end
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    initial begin
        tick(12);
        rst = 1'b0;
        rd(CMS_MULCTL_ADDR);
        chkByte("mulctl reset", CMS_MULCTL_RESET, rv);
        rd(CMS_CLOCK_SELECT_REG_ADDR);
        chkByte("clock_select_reg reset", CMS_CLOCK_SELECT_REG_RESET, rv);
        countTicks();
        chkCount("sys int stopped", 0, sysCnt);
        intOscOn = 1'b1;
        wr(CMS_CLOCK_SELECT_REG_ADDR, 8'h01);
        countTicks();
        chkCount("sys ext off", 0, sysCnt);
        extOscEnable = 1'b1;
        tick(30);
        chkByte("xtal early", 8'h00, {7'h00, crystalValid});
        tick(100);
        chkByte("xtal settled", 8'h01, {7'h00, crystalValid});
        extOscEnable = 1'b0;
        tick(2);
        chkByte("xtal off", 8'h00, {7'h00, crystalValid});
        extOscEnable = 1'b1;
        tick(130);
        chkByte("xtal again", 8'h01, {7'h00, crystalValid});
        for (int s = 3; s >= 0; s--) begin
            bringUp(2'(s));
            chkByte("mul lock", (s == 3) ? 8'h80 : 8'hA0, rv & 8'hA0);
        end
        foreach (rows[i]) begin
            wr(CMS_CLOCK_SELECT_REG_ADDR, rows[i].sel);
            rd(CMS_CLOCK_SELECT_REG_ADDR);
            chkByte("clock_select_reg", rows[i].rdExp, rv);
            tick(20);
            countTicks();
            chkCount("sys ticks", rows[i].sysN, sysCnt);
            chkCount("usb ticks", rows[i].usbN, usbCnt);
        end
        wr(CMS_MULCTL_ADDR, 8'h1E);
        rd(CMS_MULCTL_ADDR);
        chkByte("mul disabled", 8'h02, rv);
        wr(CMS_MULCTL_ADDR, 8'h00);
        wr(CMS_MULCTL_ADDR, 8'hC0);
        tick(300);
        rd(CMS_MULCTL_ADDR);
        chkByte("init from off", 8'h80, rv & 8'hA0);
        summarize();
    end
endmodule
